// file: dcm_core.sv
// command decode, mode registers and burst sequencing of a ddr sdram device
// ****************************************************************
// Notes on behaviour
// - burst columns increment or xor, wrapping
// - low column bits pick start, rest block
// - mode set with op bits zero: normal
// - op bit 8 alone set: dll reset
// - bank bits select mode or extended register
// - extended register holds dll and drive
// - dll enabled, and re-enabled leaving self refresh
// - deselect and no-operation act identically
// - activate opens row in bank
// - column command starts read or write burst
// - address bit 10 gives auto precharge
// - precharge one bank or all banks
// - refresh: auto with cke, self without
// - refresh uses internal row counter
// - cke high except self refresh
// - data mask high blocks write element
// - mode fields: length, type, latency, op
// - read data appears latency clocks later
// - dll reset bit clears itself
// ****************************************************************
`timescale 1ns/1ps
module dcm_core
    import dcm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [dcm_pkg::BANK_W-1:0] ba,
    input wire logic [dcm_pkg::ADDR_W-1:0] addr,
    input wire logic [dcm_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_mask,
    output logic [dcm_pkg::DATA_W-1:0] wr_out_data,
    output logic wr_out_valid,
    input wire logic wr_out_ready,
    output logic wr_in_ready,
    output logic [dcm_pkg::ADDR_W-1:0] mode_reg,
    output logic [dcm_pkg::ADDR_W-1:0] ext_mode_reg,
    output logic dll_enabled,
    output logic dll_reset_pulse,
    output logic [3:0] bank_open,
    output logic [dcm_pkg::ADDR_W-1:0] refresh_row,
    output logic self_refresh,
    output logic [dcm_pkg::COL_W-1:0] burst_col,
    output logic burst_valid,
    output logic burst_is_write,
    output logic burst_ap,
    output logic rd_data_start,
    output logic reserved_cmd
);
    import dcm_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [2:0] blen_mask(input logic [2:0] bl);
        unique case (bl)
            BL_2: blen_mask = 3'h1;
            BL_4: blen_mask = 3'h3;
            BL_8: blen_mask = 3'h7;
            default: blen_mask = 3'h0;
        endcase
    endfunction

    function automatic logic [COL_W-1:0] burst_addr(input logic [COL_W-1:0] start,
            input logic [2:0] idx, input logic [2:0] msk, input logic il);
        logic [2:0] low;
        low = il ? (start[2:0] ^ idx) : (start[2:0] + idx);
        burst_addr = {start[COL_W-1:3], (start[2:0] & ~msk) | (low & msk)};
    endfunction

    function automatic logic [2:0] lat_clk(input logic [2:0] cl);
        unique case (cl)
            CL_2: lat_clk = 3'h2;
            CL_25: lat_clk = 3'h2;
            CL_3: lat_clk = 3'h3;
            default: lat_clk = 3'h3;
        endcase
    endfunction

    // ****************************************************************
    // command decode
    // ****************************************************************
    logic [3:0] cmd;
    logic is_nop, is_act, is_rd, is_wr, is_bst, is_pre, is_ref, is_lmr;
    always_comb begin
        cmd = cs_n ? CMD_NOP : {1'b0, ras_n, cas_n, we_n};
        is_nop = (cmd == CMD_NOP);
        is_act = (cmd == CMD_ACT) && cke;
        is_rd = (cmd == CMD_RD) && cke;
        is_wr = (cmd == CMD_WR) && cke;
        is_bst = (cmd == CMD_BST) && cke;
        is_pre = (cmd == CMD_PRE) && cke;
        is_ref = (cmd == CMD_REF);
        is_lmr = (cmd == CMD_LMR) && cke;
    end

    // ****************************************************************
    // state
    // ****************************************************************
    dcm_state_t st_q, st_d;
    logic [ADDR_W-1:0] mr_q, mr_d, emr_q, emr_d, rrow_q, rrow_d;
    logic [3:0] open_q, open_d;
    logic dllrst_q, dllrst_d, rsv_q, rsv_d, self_q, self_d;
    logic [COL_W-1:0] start_q, start_d, bcol_q, bcol_d;
    logic [2:0] idx_q, idx_d;
    logic bv_q, bv_d, bw_q, bw_d, ap_q, ap_d, il_q, il_d;
    logic [1:0] bbank_q, bbank_d;
    logic [2:0] msk_q, msk_d;
    logic [2:0] lat_q, lat_d;
    logic rds_q, rds_d;
    logic [2:0] msk_now;
    logic dllen_q, dllen_d;

    always_comb begin
        st_d = st_q;
        mr_d = mr_q;
        emr_d = emr_q;
        rrow_d = rrow_q;
        open_d = open_q;
        dllrst_d = 1'b0;
        rsv_d = 1'b0;
        self_d = self_q;
        start_d = start_q;
        idx_d = idx_q;
        bv_d = 1'b0;
        bw_d = bw_q;
        ap_d = ap_q;
        il_d = il_q;
        bbank_d = bbank_q;
        msk_d = msk_q;
        bcol_d = bcol_q;
        lat_d = (lat_q != 3'h0) ? lat_q - 3'h1 : 3'h0;
        rds_d = (lat_q == 3'h1);
        msk_now = blen_mask(mr_q[MR_BL_LSB +: 3]);
        unique case (st_q)
            DCM_SELF: begin
                if (cke) begin
                    st_d = DCM_IDLE;
                    self_d = 1'b0;
                    emr_d[EMR_DLL_DIS_BIT] = 1'b0;
                end
            end
            default: begin
                if (st_q == DCM_BURST) begin
                    bv_d = 1'b1;
                    bcol_d = burst_addr(start_q, idx_q, msk_q, il_q);
                    idx_d = idx_q + 3'h1;
                    if (idx_q == msk_q || is_bst) begin
                        st_d = DCM_IDLE;
                        if (ap_q && !is_bst) begin
                            open_d[bbank_q] = 1'b0;
                        end
                    end
                end
                if (is_ref) begin
                    rrow_d = rrow_q + 13'h0001;
                    if (!cke) begin
                        st_d = DCM_SELF;
                        self_d = 1'b1;
                    end
                end else if (is_act) begin
                    open_d[ba] = 1'b1;
                end else if (is_pre) begin
                    if (addr[AP_BIT]) begin
                        open_d = 4'h0;
                    end else begin
                        open_d[ba] = 1'b0;
                    end
                end else if (is_rd || is_wr) begin
                    st_d = DCM_BURST;
                    start_d = addr[COL_W-1:0] & ~(COL_W'(1) << AP_BIT);
                    start_d[AP_BIT] = addr[COL_W-1]; // column bit 11 lands here
                    start_d[COL_W-1] = 1'b0;
                    idx_d = 3'h0;
                    bw_d = is_wr;
                    ap_d = addr[AP_BIT];
                    il_d = mr_q[MR_BT_BIT];
                    msk_d = msk_now;
                    bbank_d = ba;
                    if (is_rd) begin
                        lat_d = lat_clk(mr_q[MR_CL_LSB +: 3]);
                    end
                end else if (is_lmr) begin
                    if (ba == BA_MR) begin
                        if (addr[ADDR_W-1:MR_OP_LSB] == OP_NORMAL) begin
                            mr_d = addr;
                        end else if (addr[ADDR_W-1:MR_OP_LSB] == OP_DLLRST) begin
                            mr_d = addr & ~(ADDR_W'(1) << MR_DLLRST_BIT);
                            dllrst_d = 1'b1;
                        end else begin
                            rsv_d = 1'b1;
                        end
                    end else if (ba == BA_EMR) begin
                        emr_d = addr;
                    end else begin
                        rsv_d = 1'b1;
                    end
                end else if (!is_nop && cke) begin
                    rsv_d = 1'b0;
                end else if (!cke && !is_nop) begin
                    rsv_d = 1'b1;
                end
            end
        endcase
        dllen_d = ~emr_d[EMR_DLL_DIS_BIT];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= DCM_IDLE;
            mr_q <= MR_RESET;
            emr_q <= EMR_RESET;
            rrow_q <= '0;
            open_q <= 4'h0;
            dllrst_q <= 1'b0;
            rsv_q <= 1'b0;
            self_q <= 1'b0;
            start_q <= '0;
            idx_q <= 3'h0;
            bv_q <= 1'b0;
            bw_q <= 1'b0;
            ap_q <= 1'b0;
            il_q <= 1'b0;
            bbank_q <= 2'h0;
            msk_q <= 3'h0;
            bcol_q <= '0;
            lat_q <= 3'h0;
            rds_q <= 1'b0;
            dllen_q <= ~EMR_RESET[EMR_DLL_DIS_BIT];
        end else begin
            st_q <= st_d;
            mr_q <= mr_d;
            emr_q <= emr_d;
            rrow_q <= rrow_d;
            open_q <= open_d;
            dllrst_q <= dllrst_d;
            rsv_q <= rsv_d;
            self_q <= self_d;
            start_q <= start_d;
            idx_q <= idx_d;
            bv_q <= bv_d;
            bw_q <= bw_d;
            ap_q <= ap_d;
            il_q <= il_d;
            bbank_q <= bbank_d;
            msk_q <= msk_d;
            bcol_q <= bcol_d;
            lat_q <= lat_d;
            rds_q <= rds_d;
            dllen_q <= dllen_d;
        end
    end

    // ****************************************************************
    // write data path
    // ****************************************************************
    logic wf_valid;
    logic wf_ready;
    logic [DATA_W-1:0] wf_data;
    logic wir_q, wir_d;

    always_comb begin
        wir_d = wf_ready;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wir_q <= 1'b0;
        end else begin
            wir_q <= wir_d;
        end
    end

    dcm_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wfifo (
        .clk(sys_clk),
        .rst(rst),
        .in_data(wr_data),
        .in_valid(bv_q && bw_q && !wr_mask),
        .in_ready(wf_ready),
        .out_data(wf_data),
        .out_valid(wf_valid),
        .out_ready(wr_out_ready)
    );

    // fifo read stage is a flop; no extra stage, so valid and ready meet in one cycle
    assign wr_out_data = wf_data;
    assign wr_out_valid = wf_valid;
    assign wr_in_ready = wir_q;
    assign mode_reg = mr_q;
    assign ext_mode_reg = emr_q;
    assign dll_enabled = dllen_q;
    assign dll_reset_pulse = dllrst_q;
    assign bank_open = open_q;
    assign refresh_row = rrow_q;
    assign self_refresh = self_q;
    assign burst_col = bcol_q;
    assign burst_valid = bv_q;
    assign burst_is_write = bw_q;
    assign burst_ap = ap_q;
    assign rd_data_start = rds_q;
    assign reserved_cmd = rsv_q;
endmodule

// file: dcm_pkg.sv
// constants and types for the ddr command and mode logic
package dcm_pkg;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;
    localparam int COL_W = 12;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 8;
    // mode register fields
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_OP_LSB = 7;
    localparam int MR_DLLRST_BIT = 8;
    localparam int AP_BIT = 10;
    localparam int EMR_DLL_DIS_BIT = 0;
    localparam int EMR_DRV_BIT = 1;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [2:0] CL_25 = 3'h6;
    localparam logic [5:0] OP_NORMAL = 6'h00;
    localparam logic [5:0] OP_DLLRST = 6'h02;
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR = 2'h1;
    localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [CNT_W-1:0] DLL_LOCK_CYC = 8'hc8;
    typedef enum logic [2:0] {
        DCM_IDLE = 3'b001,
        DCM_BURST = 3'b010,
        DCM_SELF = 3'b100
    } dcm_state_t;
endpackage

// file: dcm_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module dcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] rd_q, rd_d;
    logic ov_q, ov_d;
    logic push, pop;

    always_comb begin
        // the output stage counts toward depth, so at most DEPTH words are held
        in_ready = (cnt_q + (AW+1)'(ov_q)) < (AW+1)'(DEPTH);
        push = in_valid && in_ready;
        pop = (cnt_q != '0) && (!ov_q || out_ready);
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        rd_d = pop ? mem_q[rp_q] : rd_q;
        ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rd_q <= '0;
            ov_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            ov_q <= ov_d;
        end
    end

    assign out_data = rd_q;
    assign out_valid = ov_q;
endmodule

// file: dcm_core_assertions.sv
// concurrent checks on the ports of the ddr command and mode logic
`timescale 1ns/1ps
module dcm_core_assertions
    import dcm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [dcm_pkg::BANK_W-1:0] ba,
    input wire logic [dcm_pkg::ADDR_W-1:0] addr,
    input wire logic [dcm_pkg::ADDR_W-1:0] mode_reg,
    input wire logic [dcm_pkg::ADDR_W-1:0] ext_mode_reg,
    input wire logic dll_enabled,
    input wire logic dll_reset_pulse,
    input wire logic [3:0] bank_open,
    input wire logic [dcm_pkg::ADDR_W-1:0] refresh_row,
    input wire logic self_refresh,
    input wire logic burst_ap,
    input wire logic rd_data_start,
    input wire logic reserved_cmd
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire live = cke && !self_refresh;
    wire lmr = live && cmd == CMD_LMR;
    nop_no_effect_a: assert property (live && cs_n |=> $stable(mode_reg) && $stable(ext_mode_reg))
        else $error("deselect changed a mode register");
    act_opens_bank_a: assert property (live && cmd == CMD_ACT |=> bank_open[$past(ba)])
        else $error("activate did not open the bank");
    pre_all_a: assert property (live && cmd == CMD_PRE && addr[AP_BIT] |=> bank_open == 4'h0)
        else $error("precharge all left a bank open");
    mode_store_a: assert property (lmr && ba == BA_MR && addr[12:7] == OP_NORMAL |=> mode_reg == $past(addr))
        else $error("mode register not stored");
    dll_reset_a: assert property (lmr && ba == BA_MR && addr[12:7] == OP_DLLRST |=> mode_reg == ($past(addr) & 13'h1eff) ##[0:1] dll_reset_pulse)
        else $error("dll reset not handled");
    reserved_bank_a: assert property (lmr && ba[1] |-> ##[1:2] reserved_cmd)
        else $error("reserved bank select not flagged");
    refresh_count_a: assert property (live && cmd == CMD_REF |=> refresh_row == $past(refresh_row) + 13'h1)
        else $error("refresh counter did not advance");
    dll_exit_a: assert property ($fell(self_refresh) |-> ##[0:1] dll_enabled)
        else $error("dll not enabled after self refresh");
    read_latency_a: assert property (live && cmd == CMD_RD && mode_reg[6:4] == CL_3 |-> ##[3:4] rd_data_start)
        else $error("read data start late");
    auto_pre_a: assert property (live && (cmd == CMD_RD || cmd == CMD_WR) && addr[AP_BIT] |-> ##[1:3] burst_ap)
        else $error("auto precharge not flagged");
endmodule
bind dcm_core dcm_core_assertions i_chk (.sys_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .mode_reg, .ext_mode_reg, .dll_enabled, .dll_reset_pulse, .bank_open, .refresh_row,
    .self_refresh, .burst_ap, .rd_data_start, .reserved_cmd);

// file: dcm_ctrl_model.sv
// controller-side model driving the command pins and write data
`timescale 1ns/1ps
module dcm_ctrl_model
    import dcm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic dll_enabled,
    input wire logic burst_valid,
    input wire logic burst_is_write,
    input wire logic [3:0] bank_open,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [dcm_pkg::BANK_W-1:0] ba,
    output logic [dcm_pkg::ADDR_W-1:0] addr,
    output logic [dcm_pkg::DATA_W-1:0] wr_data,
    output logic wr_mask
);
    logic [7:0] since_q = 8'h00;
    logic [2:0] elem_q = 3'h0;
    logic [7:0] mask_q = 8'h00;
    logic clr_q = 1'b0;
    logic late = 1'b0;
    logic [7:0] pat;
    wire wr_el = burst_valid && burst_is_write;
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 2'h0;
        addr = 13'h0000;
    end
    always @(posedge sys_clk) begin
        if (rst || !dll_enabled) since_q <= 8'h00;
        else if (since_q != 8'hff) since_q <= since_q + 8'h01;
        if (clr_q) elem_q <= 3'h0;
        else if (wr_el) elem_q <= elem_q + 3'h1;
    end
    assign pat = 8'ha0 + {5'h00, elem_q};
    // data shown only in write element cycles, inverted otherwise
    assign wr_data = wr_el ? pat : ~pat;
    assign wr_mask = wr_el ? mask_q[elem_q] : ~mask_q[elem_q];
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                         input logic [7:0] m);
        int n;
        n = 0;
        while (n < 300 && ((c == CMD_LMR && (burst_valid || bank_open != 4'h0))
               || (c == CMD_RD && since_q < DLL_LOCK_CYC))) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 300) late = 1'b1;
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        mask_q <= m;
        clr_q <= (c == CMD_WR);
        @(posedge sys_clk);
        cs_n <= 1'b1;
        clr_q <= 1'b0;
        // released lines must not keep the last value
        ba <= ~b;
        addr <= ~a;
    endtask
    task automatic set_cke(input logic k);
        @(posedge sys_clk);
        cke <= k;
    endtask
endmodule

// file: dcm_core_tb.sv
// self-checking bench for the ddr command and mode logic
`timescale 1ns/1ps
module dcm_core_tb;
    import dcm_pkg::*;
    logic sys_clk, rst, cke, cs_n, ras_n, cas_n, we_n, wr_mask, wr_out_valid, wr_out_ready;
    logic wr_in_ready, dll_enabled, dll_reset_pulse, self_refresh, burst_valid, burst_is_write;
    logic burst_ap, rd_data_start, reserved_cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr, mode_reg, ext_mode_reg, refresh_row;
    logic [DATA_W-1:0] wr_data, wr_out_data;
    logic [COL_W-1:0] burst_col;
    logic [3:0] bank_open;
    logic [7:0] exp_q[$];
    // length code, interleave, auto precharge, start column
    logic [14:0] bursts[5] = '{15'h1001, 15'h2401, 15'h2801, 15'h381d, 15'h342f};
    int n_fail = 0;
    int checked = 0;
    int n_res = 0;
    int n_dllrst = 0;
    int n_bv = 0;
    int i;
    dcm_core i_dut (.sys_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .wr_data,
        .wr_mask, .wr_out_data, .wr_out_valid, .wr_out_ready, .wr_in_ready, .mode_reg,
        .ext_mode_reg, .dll_enabled, .dll_reset_pulse, .bank_open, .refresh_row, .self_refresh,
        .burst_col, .burst_valid, .burst_is_write, .burst_ap, .rd_data_start, .reserved_cmd);
    dcm_ctrl_model i_ctrl (.sys_clk, .rst, .dll_enabled, .burst_valid, .burst_is_write,
        .bank_open, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .wr_data, .wr_mask);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_res <= n_res + int'(reserved_cmd === 1'b1);
        n_dllrst <= n_dllrst + int'(dll_reset_pulse === 1'b1);
        n_bv <= n_bv + int'(burst_valid === 1'b1);
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (i_ctrl.late === 1'b1) n_fail++;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        i_ctrl.issue(c, b, a, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic burst(input logic [14:0] c);
        logic [9:0] m, col, exp;
        int k, t, lat;
        m = (10'h1 << c[14:12]) - 10'h1;
        col = c[9:0];
        k = 0;
        lat = 0;
        op(CMD_LMR, BA_MR, {OP_NORMAL, CL_3, c[11], c[14:12]});
        i_ctrl.issue(CMD_RD, 2'h0, {2'h0, c[10], col}, 8'h00);
        for (t = 0; t < 20; t++) begin
            #1;
            exp = c[11] ? col ^ 10'(k) : (col & ~m) | ((col + 10'(k)) & m);
            if (burst_valid === 1'b1) begin
                check({4'h0, burst_col}, {6'h0, exp});
                if (k == 0) check(burst_ap, c[10]);
                if (k == 0) check(burst_is_write, 1'b0);
                k++;
            end
            if (rd_data_start === 1'b1) lat = t;
            @(posedge sys_clk);
        end
        check(16'(k), 16'(m) + 16'h1);
        check(16'(lat), 16'h3);
    endtask
    task automatic drain();
        int t;
        for (t = 0; t < 80 && exp_q.size() > 0; t++) begin
            @(posedge sys_clk);
            if (wr_out_valid === 1'b1 && wr_out_ready === 1'b1) begin
                check(wr_out_data, exp_q.pop_front());
            end
            wr_out_ready <= t[1];
        end
        if (exp_q.size() > 0) begin
            n_fail++;
            results();
        end
    endtask
    initial begin
        rst = 1'b1;
        wr_out_ready = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check(mode_reg, MR_RESET);
        check(dll_enabled, 1'b1);
        op(CMD_LMR, BA_MR, {OP_DLLRST, CL_3, 1'b0, BL_4});
        check(mode_reg, {OP_NORMAL, CL_3, 1'b0, BL_4});
        check(16'(n_dllrst), 16'h1);
        op(CMD_LMR, BA_MR, {OP_NORMAL, CL_25, 1'b1, BL_8});
        op(CMD_LMR, BA_MR, 13'h0232);
        op(CMD_LMR, 2'h2, 13'h0011);
        check(mode_reg, {OP_NORMAL, CL_25, 1'b1, BL_8});
        check(16'(n_res), 16'h2);
        op(CMD_LMR, BA_EMR, 13'h0003);
        check(ext_mode_reg, 13'h0003);
        check(dll_enabled, 1'b0);
        op(CMD_LMR, BA_EMR, 13'h0002);
        op(CMD_LMR, BA_MR, {OP_DLLRST, CL_3, 1'b0, BL_4});
        check(dll_enabled, 1'b1);
        for (i = 0; i < 5; i++) burst(bursts[i]);
        // terminate a plain read right after its second element
        op(CMD_LMR, BA_MR, {OP_NORMAL, CL_3, 1'b0, BL_8});
        i_ctrl.issue(CMD_RD, 2'h0, 13'h0000, 8'h00);
        i = n_bv;
        i_ctrl.issue(CMD_BST, 2'h0, 13'h0000, 8'h00);
        repeat (12) @(posedge sys_clk);
        #1;
        check(16'(n_bv - i), 16'h2);
        op(CMD_ACT, 2'h2, 13'h1abc);
        op(CMD_ACT, 2'h0, 13'h0005);
        op(CMD_NOP, 2'h1, 13'h0400);
        check(bank_open, 4'h5);
        op(CMD_PRE, 2'h2, 13'h0000);
        check(bank_open, 4'h1);
        op(CMD_PRE, 2'h1, 13'h0400);
        check(bank_open, 4'h0);
        op(CMD_REF, 2'h3, 13'h1fff);
        op(CMD_REF, 2'h1, 13'h0000);
        check(refresh_row, 13'h0002);
        op(CMD_LMR, BA_EMR, 13'h0001);
        i_ctrl.set_cke(1'b0);
        op(CMD_REF, 2'h0, 13'h0000);
        check(self_refresh, 1'b1);
        op(CMD_ACT, 2'h1, 13'h0003);
        check(bank_open, 4'h0);
        i_ctrl.set_cke(1'b1);
        repeat (3) @(posedge sys_clk);
        #1;
        check(self_refresh, 1'b0);
        check(dll_enabled, 1'b1);
        op(CMD_LMR, BA_MR, {OP_NORMAL, CL_3, 1'b0, BL_8});
        i_ctrl.issue(CMD_WR, 2'h0, 13'h0000, 8'h00);
        repeat (14) @(posedge sys_clk);
        #1;
        check(wr_in_ready, 1'b0);
        check(burst_is_write, 1'b1);
        for (i = 0; i < 8; i++) exp_q.push_back(8'ha0 + 8'(i));
        drain();
        op(CMD_LMR, BA_MR, {OP_NORMAL, CL_3, 1'b0, BL_4});
        i_ctrl.issue(CMD_WR, 2'h0, 13'h0000, 8'h02);
        exp_q = '{8'ha0, 8'ha2, 8'ha3};
        drain();
        repeat (4) @(posedge sys_clk);
        #1;
        check(wr_in_ready, 1'b1);
        results();
    end
endmodule
